// ### irq_ctl_pkg.sv
// Shared constants of the interrupt and key-return controller.
// Assumes a 32-bit APB slave with byte addresses; each register is one word.
package irq_ctl_pkg;
	localparam int NUM_EXT = 8;
	localparam int NUM_PER = 4;
	localparam int NUM_SRC = 16;
	localparam int IDX_W   = 4;

	// Register byte offsets
	localparam logic [7:0] OFF_REQ      = 8'h00;
	localparam logic [7:0] OFF_REQ_CLR  = 8'h04;
	localparam logic [7:0] OFF_MASK     = 8'h08;
	localparam logic [7:0] OFF_PRIO     = 8'h0C;
	localparam logic [7:0] OFF_RISE_EN  = 8'h10;
	localparam logic [7:0] OFF_FALL_EN  = 8'h14;
	localparam logic [7:0] OFF_EXT_SEL  = 8'h18;
	localparam logic [7:0] OFF_KEY_MODE = 8'h1C;
	localparam logic [7:0] OFF_PULLUP   = 8'h20;
	localparam logic [7:0] OFF_PORT7    = 8'h24;
	localparam logic [7:0] OFF_IE       = 8'h28;
	localparam logic [7:0] OFF_EVT_STAT = 8'h2C;
	localparam logic [7:0] OFF_EVT_MASK = 8'h30;

	// Request flag layout
	localparam int POS_EXT = 0;
	localparam int POS_KEY = 8;
	localparam int POS_PER = 9;
	// Bits 13..15 (upper byte bits 5..7) hold no source
	localparam logic [15:0] REQ_VALID = 16'h1FFF;

	// Reset values
	localparam logic [15:0] MASK_RST  = 16'hFFFF;
	localparam logic [15:0] PRIO_RST  = 16'hFFFF;
	localparam logic [7:0]  BYTE_RST  = 8'h00;
	localparam logic [2:0]  EVT_RST   = 3'h0;

	// Event status layout
	localparam int EVT_W       = 3;
	localparam int EVT_KEY     = 0;
	localparam int EVT_EXT     = 1;
	localparam int EVT_TRAP    = 2;
endpackage

// ### key_if.sv
// Link between the controller and its key-return detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface key_if;
	logic [7:0] key_mode;
	logic [7:0] pins;
	logic       key_event;
	logic [7:0] port_data;
	modport ctrl (output key_mode, output pins,
		input key_event, input port_data);
	modport unit (input key_mode, input pins,
		output key_event, output port_data);
endinterface

// ### key_return_unit.sv
// Key-return detector on the eight-bit port.
// Assumes pins are synchronous and pulled up where enabled.
`timescale 1ns/1ps
module key_return_unit (
	input  wire logic clk_in,
	input  wire logic srst_in,
	key_if.unit       kb
);
	logic       level;
	logic       prev_r;
	logic       prev_nxt;
	logic [7:0] data_r;
	logic [7:0] data_nxt;

	////////////////////////////////////////////////////////////////////////
	// Disabled inputs count as high, so they never cause a key event
	always_comb begin
		level    = &(kb.pins | ~kb.key_mode);
		prev_nxt = level;
		data_nxt = kb.pins;
	end

	// A mode change that unmasks a low pin drops the level too: flag set
	assign kb.key_event = prev_r & ~level;
	// Every pin reads back, so non-key bits still serve as a port
	assign kb.port_data = data_r;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			prev_r <= 1'b1;
			data_r <= 8'h00;
		end else begin
			prev_r <= prev_nxt;
			data_r <= data_nxt;
		end
	end
endmodule

// ### irq_ctl.sv
// Interrupt controller with external edge and key-return sources, APB side.
// Assumes a CPU core that pulses ack, trap and IE controls synchronously.
`timescale 1ns/1ps
module irq_ctl #(
	parameter int NUM_EXT = irq_ctl_pkg::NUM_EXT,
	parameter int NUM_PER = irq_ctl_pkg::NUM_PER
) (
	input  wire logic                          clk_in,
	input  wire logic                          srst_in,
	input  wire logic                          psel_in,
	input  wire logic                          penable_in,
	input  wire logic                          pwrite_in,
	input  wire logic [7:0]                    paddr_in,
	input  wire logic [31:0]                   pwdata_in,
	output logic      [31:0]                   prdata_out,
	output logic                               pready_out,
	output logic                               pslverr_out,
	input  wire logic [7:0]                    ext_pin_in,
	input  wire logic [7:0]                    port7_pin_in,
	output logic      [7:0]                    port7_pullup_out,
	input  wire logic [3:0]                    periph_req_in,
	input  wire logic                          ie_set_in,
	input  wire logic                          ie_clr_in,
	input  wire logic                          trap_in,
	input  wire logic                          hold_in,
	input  wire logic                          ack_in,
	input  wire logic [irq_ctl_pkg::IDX_W-1:0] ack_idx_in,
	output logic                               irq_req_out,
	output logic      [irq_ctl_pkg::IDX_W-1:0] irq_idx_out,
	output logic                               irq_prio_out,
	output logic                               ie_out,
	output logic                               irq_out
);
	localparam int NS = irq_ctl_pkg::NUM_SRC;
	localparam int EW = irq_ctl_pkg::EVT_W;

	key_if kb ();

	key_return_unit u_key (
		.clk_in  (clk_in),
		.srst_in (srst_in),
		.kb      (kb)
	);

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic [NS-1:0] req_r,  req_nxt;
	logic [NS-1:0] mask_r, mask_nxt;
	logic [NS-1:0] prio_r, prio_nxt;
	logic [7:0]    rise_r, rise_nxt;
	logic [7:0]    fall_r, fall_nxt;
	logic [7:0]    sel_r,  sel_nxt;
	logic [7:0]    kmode_r, kmode_nxt;
	logic [7:0]    pull_r, pull_nxt;
	logic          ie_r,   ie_nxt;
	logic [EW-1:0] evst_r, evst_nxt;
	logic [EW-1:0] evmk_r, evmk_nxt;
	logic [31:0]   rdata_r, rdata_nxt;
	logic          err_r,  err_nxt;

	logic          wr_en;
	logic          rd_setup;
	logic          hit;
	logic [7:0]    det_lvl;
	logic [7:0]    det_prev_r;
	logic [7:0]    ext_edge;
	logic [NS-1:0] req_set;
	logic [NS-1:0] pend;
	logic [EW-1:0] evt_set;

	logic                          cand_r, cand_nxt;
	logic [irq_ctl_pkg::IDX_W-1:0] cidx_r, cidx_nxt;
	logic                          cprio_r, cprio_nxt;

	assign kb.key_mode = kmode_r;
	assign kb.pins     = port7_pin_in;

	////////////////////////////////////////////////////////////////////////
	// APB decode: zero wait states, writes at the access edge
	assign wr_en      = psel_in & penable_in & pwrite_in;
	assign rd_setup   = psel_in & ~penable_in;
	assign pready_out = 1'b1;
	assign prdata_out = rdata_r;
	assign pslverr_out = err_r & psel_in & penable_in;

	always_comb begin
		hit = 1'b1;
		rdata_nxt = rdata_r;
		case (paddr_in)
			irq_ctl_pkg::OFF_REQ:      rdata_nxt = {16'h0000, req_r};
			irq_ctl_pkg::OFF_REQ_CLR:  rdata_nxt = 32'h0000_0000;
			irq_ctl_pkg::OFF_MASK:     rdata_nxt = {16'h0000, mask_r};
			irq_ctl_pkg::OFF_PRIO:     rdata_nxt = {16'h0000, prio_r};
			irq_ctl_pkg::OFF_RISE_EN:  rdata_nxt = {24'h00_0000, rise_r};
			irq_ctl_pkg::OFF_FALL_EN:  rdata_nxt = {24'h00_0000, fall_r};
			irq_ctl_pkg::OFF_EXT_SEL:  rdata_nxt = {24'h00_0000, sel_r};
			irq_ctl_pkg::OFF_KEY_MODE: rdata_nxt = {24'h00_0000, kmode_r};
			irq_ctl_pkg::OFF_PULLUP:   rdata_nxt = {24'h00_0000, pull_r};
			irq_ctl_pkg::OFF_PORT7:
				rdata_nxt = {24'h00_0000, kb.port_data};
			irq_ctl_pkg::OFF_IE:       rdata_nxt = {31'h0000_0000, ie_r};
			irq_ctl_pkg::OFF_EVT_STAT: rdata_nxt = {29'h0000_0000, evst_r};
			irq_ctl_pkg::OFF_EVT_MASK: rdata_nxt = {29'h0000_0000, evmk_r};
			default: begin
				hit = 1'b0;
				rdata_nxt = 32'h0000_0000;
			end
		endcase
		err_nxt = err_r;
		if (rd_setup) begin
			err_nxt = ~hit;
		end else begin
			rdata_nxt = rdata_r;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_r <= 32'h0000_0000;
			err_r   <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			err_r   <= err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// External pin edge detection. The pin is seen only in interrupt mode,
	// so leaving that mode with a high pin looks like a falling edge.
	always_comb begin
		det_lvl  = ext_pin_in & sel_r;
		ext_edge = (det_lvl & ~det_prev_r & rise_r)
			| (~det_lvl & det_prev_r & fall_r);
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			det_prev_r <= 8'h00;
		end else begin
			det_prev_r <= det_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Request flags. Hardware sets win over any clear in the same cycle.
	always_comb begin
		req_set = '0;
		req_set[irq_ctl_pkg::POS_EXT +: 8] = ext_edge;
		req_set[irq_ctl_pkg::POS_KEY]      = kb.key_event;
		req_set[irq_ctl_pkg::POS_PER +: 4] = periph_req_in;
		req_nxt = req_r;
		if (wr_en && paddr_in == irq_ctl_pkg::OFF_REQ) begin
			req_nxt = pwdata_in[15:0];
		end
		if (wr_en && paddr_in == irq_ctl_pkg::OFF_REQ_CLR) begin
			req_nxt = req_nxt & ~pwdata_in[15:0];
		end
		if (ack_in) begin
			req_nxt[ack_idx_in] = 1'b0;
		end
		req_nxt = (req_nxt | req_set) & irq_ctl_pkg::REQ_VALID;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			req_r <= '0;
		end else begin
			req_r <= req_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software-written configuration
	always_comb begin
		mask_nxt  = mask_r;
		prio_nxt  = prio_r;
		rise_nxt  = rise_r;
		fall_nxt  = fall_r;
		sel_nxt   = sel_r;
		kmode_nxt = kmode_r;
		pull_nxt  = pull_r;
		evmk_nxt  = evmk_r;
		if (wr_en) begin
			case (paddr_in)
				irq_ctl_pkg::OFF_MASK:     mask_nxt  = pwdata_in[15:0];
				irq_ctl_pkg::OFF_PRIO:     prio_nxt  = pwdata_in[15:0];
				irq_ctl_pkg::OFF_RISE_EN:  rise_nxt  = pwdata_in[7:0];
				irq_ctl_pkg::OFF_FALL_EN:  fall_nxt  = pwdata_in[7:0];
				irq_ctl_pkg::OFF_EXT_SEL:  sel_nxt   = pwdata_in[7:0];
				irq_ctl_pkg::OFF_KEY_MODE: kmode_nxt = pwdata_in[7:0];
				irq_ctl_pkg::OFF_PULLUP:   pull_nxt  = pwdata_in[7:0];
				irq_ctl_pkg::OFF_EVT_MASK: evmk_nxt  = pwdata_in[EW-1:0];
				default: begin
					mask_nxt = mask_r;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mask_r  <= irq_ctl_pkg::MASK_RST;
			prio_r  <= irq_ctl_pkg::PRIO_RST;
			rise_r  <= irq_ctl_pkg::BYTE_RST;
			fall_r  <= irq_ctl_pkg::BYTE_RST;
			sel_r   <= irq_ctl_pkg::BYTE_RST;
			kmode_r <= irq_ctl_pkg::BYTE_RST;
			pull_r  <= irq_ctl_pkg::BYTE_RST;
			evmk_r  <= irq_ctl_pkg::EVT_RST;
		end else begin
			mask_r  <= mask_nxt;
			prio_r  <= prio_nxt;
			rise_r  <= rise_nxt;
			fall_r  <= fall_nxt;
			sel_r   <= sel_nxt;
			kmode_r <= kmode_nxt;
			pull_r  <= pull_nxt;
			evmk_r  <= evmk_nxt;
		end
	end

	assign port7_pullup_out = pull_r;

	////////////////////////////////////////////////////////////////////////
	// Global enable. Trap and acknowledge both clear it and beat a set.
	always_comb begin
		ie_nxt = ie_r;
		if (wr_en && paddr_in == irq_ctl_pkg::OFF_IE) begin
			ie_nxt = pwdata_in[0];
		end
		if (ie_set_in) begin
			ie_nxt = 1'b1;
		end
		if (ie_clr_in) begin
			ie_nxt = 1'b0;
		end
		if (trap_in || ack_in) begin
			ie_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ie_r <= 1'b0;
		end else begin
			ie_r <= ie_nxt;
		end
	end

	assign ie_out = ie_r;

	////////////////////////////////////////////////////////////////////////
	// Arbitration: high level (priority flag clear) first, then lowest index
	always_comb begin
		pend      = req_r & ~mask_r & irq_ctl_pkg::REQ_VALID;
		cand_nxt  = 1'b0;
		cidx_nxt  = '0;
		cprio_nxt = 1'b1;
		for (int i = NS - 1; i >= 0; i--) begin
			if (pend[i] && !prio_r[i]) begin
				cand_nxt  = 1'b1;
				cidx_nxt  = i[irq_ctl_pkg::IDX_W-1:0];
				cprio_nxt = 1'b0;
			end
		end
		if (!cand_nxt) begin
			for (int i = NS - 1; i >= 0; i--) begin
				if (pend[i]) begin
					cand_nxt = 1'b1;
					cidx_nxt = i[irq_ctl_pkg::IDX_W-1:0];
				end
			end
		end
		if (ack_in) begin
			cand_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cand_r  <= 1'b0;
			cidx_r  <= '0;
			cprio_r <= 1'b1;
		end else begin
			cand_r  <= cand_nxt;
			cidx_r  <= cidx_nxt;
			cprio_r <= cprio_nxt;
		end
	end

	// Hold comes only from the core; a trap never raises it, but a trap
	// in flight masks the request at once through trap_in; the enable clears a cycle later.
	assign irq_req_out = cand_r & ie_r & ~hold_in & ~trap_in;
	assign irq_idx_out  = cidx_r;
	assign irq_prio_out = cprio_r;

	////////////////////////////////////////////////////////////////////////
	// Event status, write one to clear; a new event wins over the clear
	always_comb begin
		evt_set = '0;
		evt_set[irq_ctl_pkg::EVT_KEY]  = kb.key_event;
		evt_set[irq_ctl_pkg::EVT_EXT]  = |ext_edge;
		evt_set[irq_ctl_pkg::EVT_TRAP] = trap_in;
		evst_nxt = evst_r;
		if (wr_en && paddr_in == irq_ctl_pkg::OFF_EVT_STAT) begin
			evst_nxt = evst_r & ~pwdata_in[EW-1:0];
		end
		evst_nxt = evst_nxt | evt_set;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			evst_r <= irq_ctl_pkg::EVT_RST;
		end else begin
			evst_r <= evst_nxt;
		end
	end

	assign irq_out = |(evst_r & ~evmk_r);
endmodule

// ### irq_ctl_properties.sv
// Concurrent checks on the ports of irq_ctl.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
module irq_ctl_properties (
	input	wire logic		clk_in,
	input	wire logic		srst_in,
	input	wire logic		psel_in,
	input	wire logic		penable_in,
	input	wire logic		pwrite_in,
	input	wire logic [7:0]	port7_pullup_out,
	input	wire logic		ie_set_in,
	input	wire logic		ie_clr_in,
	input	wire logic		trap_in,
	input	wire logic		hold_in,
	input	wire logic		ack_in,
	input	wire logic		irq_req_out,
	input	wire logic		ie_out,
	input	wire logic		irq_out
);
	logic	apb_wr;

	// Only a completed write may change the pull-ups or clear the event status
	assign apb_wr = psel_in && penable_in && pwrite_in;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	sequence s_trap;
		trap_in;
	endsequence
	sequence s_ack;
		ack_in && !ie_set_in;
	endsequence
	////////////////////////////////////////////////////////////
	a_trap_no_req: assert property (s_trap |-> !irq_req_out)
		else $error("request during trap");
	a_trap_ie_off: assert property (s_trap |=> !ie_out)
		else $error("enable kept after trap");
	a_hold_no_req: assert property (hold_in |-> !irq_req_out)
		else $error("request during hold");
	a_req_needs_ie: assert property (irq_req_out |-> ie_out)
		else $error("request with enable off");
	a_ack_quiets: assert property (s_ack |=> !ie_out && !irq_req_out)
		else $error("request kept after ack");
	a_ie_set_on: assert property (ie_set_in && !ie_clr_in && !trap_in
		&& !ack_in && !apb_wr |=> ie_out)
		else $error("enable not set");
	a_pullup_kept: assert property (!apb_wr |=> $stable(port7_pullup_out))
		else $error("pull-ups changed without write");
	a_irq_line_kept: assert property (irq_out && !apb_wr |=> irq_out)
		else $error("event line dropped without write");
endmodule

bind irq_ctl irq_ctl_properties props (.clk_in, .srst_in, .psel_in,
	.penable_in, .pwrite_in, .port7_pullup_out, .ie_set_in, .ie_clr_in,
	.trap_in, .hold_in, .ack_in, .irq_req_out, .ie_out, .irq_out);

// ### irq_core_model.sv
// Behavioural CPU core: acknowledges requests, then re-enables interrupts.
// Assumes a combinational request and a registered index from the controller.
`timescale 1ns/1ps
module irq_core_model (
	input	wire logic		clk_in,
	input	wire logic		srst_in,
	input	wire logic		irq_req_in,
	input	wire logic		irq_prio_in,
	input	wire logic [3:0]	irq_idx_in,
	input	wire logic		ie_in,
	input	wire logic		auto_ie_in,
	input	wire logic		slow_in,
	output	logic			ack_out = 1'b0,
	output	logic [3:0]		ack_idx_out = 4'h0,
	output	logic			ie_set_out = 1'b0,
	output	int			ack_count_out,
	output	logic [3:0]		last_idx_out,
	output	logic			last_prio_out
);
	int	wait_r;

	always @(posedge clk_in) begin
		ack_out <= 1'b0;
		ie_set_out <= 1'b0;
		// Idle index keeps moving so a stale value never looks valid
		ack_idx_out <= ~ack_idx_out;
		if (srst_in) begin
			ack_count_out <= 0;
			wait_r <= 0;
		end else if (irq_req_in && !ack_out) begin
			ack_out <= 1'b1;
			ack_idx_out <= irq_idx_in;
			last_idx_out <= irq_idx_in;
			last_prio_out <= irq_prio_in;
			ack_count_out <= ack_count_out + 1;
			wait_r <= slow_in ? 6 : 1;
		end else if (wait_r > 0) begin
			wait_r <= wait_r - 1;
		end else if (auto_ie_in && !ie_in && !ie_set_out) begin
			ie_set_out <= 1'b1;
		end
	end
endmodule

// ### interrupt_and_key_return_control_tb_top.sv
// Self-checking bench for irq_ctl with a core model on the far side.
// Assumes a 100 MHz clock and registers reached over APB.
`timescale 1ns/1ps
module interrupt_and_key_return_control_tb_top;
	logic		clk_in = 0, srst_in = 1, psel_in = 0, penable_in = 0;
	logic		pwrite_in = 0, ie_clr_in = 0, trap_in = 0, hold_in = 0;
	logic		auto_ie = 0, slow = 0, err, pready_out, pslverr_out;
	logic		ie_set_in, ack_in, irq_req_out, irq_prio_out, ie_out, irq_out;
	logic [7:0]	paddr_in = 0, ext_pin_in = 0, port7_pin_in = 0, p7;
	logic [7:0]	port7_pullup_out;
	logic		last_prio;
	logic [31:0]	pwdata_in = 0, prdata_out, q;
	logic [3:0]	periph_req_in = 0, ack_idx_in, irq_idx_out, last_idx;
	int		fail_count = 0, check_count = 0, acks, k, m;

	always #5 clk_in = ~clk_in;
	irq_ctl dut (.clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
		.ext_pin_in, .port7_pin_in, .port7_pullup_out, .periph_req_in,
		.ie_set_in, .ie_clr_in, .trap_in, .hold_in, .ack_in, .ack_idx_in,
		.irq_req_out, .irq_idx_out, .irq_prio_out, .ie_out, .irq_out);
	irq_core_model core (.clk_in, .srst_in, .irq_req_in(irq_req_out),
		.irq_prio_in(irq_prio_out), .last_prio_out(last_prio),
		.irq_idx_in(irq_idx_out), .ie_in(ie_out), .auto_ie_in(auto_ie),
		.slow_in(slow), .ack_out(ack_in), .ack_idx_out(ack_idx_in),
		.ie_set_out(ie_set_in), .ack_count_out(acks),
		.last_idx_out(last_idx));
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] bit_of(input int b);
		return 32'h0000_0001 << b;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		q = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string n, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, q);
	endtask
	task automatic wait_ack(input int n);
		for (int i = 0; i < 40 && acks < n; i++) @(posedge clk_in);
		// A core that never acknowledges must not pass silently
		if (acks < n) begin
			fail_count++;
			$display("CHECK FAILED acks expected %0d seen %0d", n, acks);
		end
	endtask
	task automatic print_verdict();
		if (fail_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		print_verdict();
	end
	initial begin
		void'($urandom(74350));
		repeat (5) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		rd("mask", irq_ctl_pkg::OFF_MASK, 32'h0000_FFFF);
		rd("prio", irq_ctl_pkg::OFF_PRIO, 32'h0000_FFFF);
		rd("unmapped", 8'h40, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, err);
		wr(irq_ctl_pkg::OFF_EXT_SEL, 32'h0000_00FF);
		wr(irq_ctl_pkg::OFF_RISE_EN, 32'h0000_00FF);
		auto_ie <= 1'b1;
		// Two pins at once: the high-level one must win whatever its index
		for (int i = 0; i < 4; i++) begin
			k = $urandom % 8;
			m = (k + 1 + $urandom % 7) % 8;
			slow <= i[0];
			wr(irq_ctl_pkg::OFF_PRIO, 32'h0000_FFFF & ~bit_of(m));
			wr(irq_ctl_pkg::OFF_MASK, 32'h0000_DFFF & ~(bit_of(k) | bit_of(m)));
			ext_pin_in <= 8'(bit_of(k) | bit_of(m));
			wait_ack(acks + 1);
			chk("first idx", m, last_idx);
			chk("first prio", 32'h0000_0000, last_prio);
			wait_ack(acks + 1);
			chk("second idx", k, last_idx);
			chk("second prio", 32'h0000_0001, last_prio);
			ext_pin_in <= 8'h00;
			rd("req acked", irq_ctl_pkg::OFF_REQ, 32'h0000_0000);
		end
		auto_ie <= 1'b0;
		wr(irq_ctl_pkg::OFF_MASK, 32'h0000_DFFF);
		wr(irq_ctl_pkg::OFF_REQ, bit_of(5));
		// Enable must be on, or the trap check below proves nothing
		wr(irq_ctl_pkg::OFF_IE, 32'h0000_0001);
		hold_in <= 1'b1;
		wr(irq_ctl_pkg::OFF_MASK, 32'h0000_DFFF & ~bit_of(5));
		k = acks;
		trap_in <= 1'b1;
		hold_in <= 1'b0;
		@(posedge clk_in);
		trap_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk("acks after trap", k, acks);
		rd("ie after trap", irq_ctl_pkg::OFF_IE, 32'h0000_0000);
		// No hold lingers after the trap: re-enabling lets it through
		wr(irq_ctl_pkg::OFF_IE, 32'h0000_0001);
		wait_ack(k + 1);
		chk("ack after trap", k + 1, acks);
		wr(irq_ctl_pkg::OFF_IE, 32'h0000_0001);
		ie_clr_in <= 1'b1;
		@(posedge clk_in);
		ie_clr_in <= 1'b0;
		rd("ie after clr", irq_ctl_pkg::OFF_IE, 32'h0000_0000);
		wr(irq_ctl_pkg::OFF_REQ, 32'h0000_1FFF);
		rd("req all", irq_ctl_pkg::OFF_REQ, 32'h0000_1FFF);
		wr(irq_ctl_pkg::OFF_REQ_CLR, bit_of(0));
		rd("req one clr", irq_ctl_pkg::OFF_REQ, 32'h0000_1FFE);
		wr(irq_ctl_pkg::OFF_MASK, 32'h0000_DFFF);
		wr(irq_ctl_pkg::OFF_FALL_EN, 32'h0000_00FF);
		ext_pin_in <= 8'hFF;
		repeat (3) @(posedge clk_in);
		wr(irq_ctl_pkg::OFF_RISE_EN, 32'h0000_0000);
		wr(irq_ctl_pkg::OFF_FALL_EN, 32'h0000_0000);
		wr(irq_ctl_pkg::OFF_REQ, 32'h0000_0000);
		wr(irq_ctl_pkg::OFF_EXT_SEL, 32'h0000_0000);
		repeat (3) @(posedge clk_in);
		rd("req port mode", irq_ctl_pkg::OFF_REQ, 32'h0000_0000);
		wr(irq_ctl_pkg::OFF_EVT_STAT, 32'h0000_0007);
		p7 = 8'($urandom);
		p7[2] = 1'b0;
		port7_pin_in <= p7;
		wr(irq_ctl_pkg::OFF_PULLUP, 32'h0000_0004);
		chk("pullups", 32'h0000_0004, port7_pullup_out);
		wr(irq_ctl_pkg::OFF_KEY_MODE, 32'h0000_0004);
		rd("key flag", irq_ctl_pkg::OFF_REQ, bit_of(8));
		chk("event line", 32'h0000_0001, irq_out);
		wr(irq_ctl_pkg::OFF_REQ_CLR, bit_of(8));
		rd("key flag clr", irq_ctl_pkg::OFF_REQ, 32'h0000_0000);
		wr(irq_ctl_pkg::OFF_EVT_MASK, 32'h0000_0001);
		chk("event masked", 32'h0000_0000, irq_out);
		wr(irq_ctl_pkg::OFF_EVT_STAT, 32'h0000_0001);
		wr(irq_ctl_pkg::OFF_EVT_MASK, 32'h0000_0000);
		chk("event cleared", 32'h0000_0000, irq_out);
		rd("port pins", irq_ctl_pkg::OFF_PORT7, {24'h00_0000, p7});
		k = $urandom % 4;
		periph_req_in <= 4'(bit_of(k));
		@(posedge clk_in);
		periph_req_in <= 4'h0;
		@(posedge clk_in);
		rd("periph flag", irq_ctl_pkg::OFF_REQ, bit_of(9 + k));
		print_verdict();
	end
endmodule
